// >>> src/rff_defs.svh
`ifndef RFF_DEFS_SVH
`define RFF_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RFF_IDX_ERR 8'h06
`define RFF_IDX_STAT 8'h07
`define RFF_IDX_DATA 8'h09
`define RFF_IDX_LEVEL 8'h0A
`define RFF_IDX_WATER 8'h0B
`define RFF_IDX_CTRL 8'h0C
`define RFF_IDX_FRAME 8'h0D

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define RFF_BIT_FLUSH 7
`define RFF_BIT_HALT 7
`define RFF_BIT_GO 6
`define RFF_BIT_IDCOPY 5
`define RFF_BIT_ROLE 4
`define RFF_BIT_LAUNCH 7
`define RFF_BIT_OVFL 4
`define RFF_BIT_HI 1
`define RFF_BIT_LO 0
`define RFF_LOW3_LSB 0
`define RFF_ALIGN_LSB 4
`define RFF_PHASE_LSB 4
`define RFF_WATER_RST 6'h08
`define RFF_MSB_POS 3'h7

// ----------------------------------------------------------------
// Sizes and codes
// ----------------------------------------------------------------
`define RFF_DEPTH 64
`define RFF_ID_LAST 4'h9
`define RFF_PHASE_IDLE 3'h0
`define RFF_PHASE_WAIT 3'h1
`define RFF_PHASE_SEND 3'h3

`endif

// >>> src/rff_pkg.sv
package rff_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rff_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rff_apb_rsp_t;

  typedef enum logic [1:0] {
    RFF_IDLE,
    RFF_WAIT,
    RFF_SEND
  } rff_phase_t;

  typedef struct packed {
    rff_apb_rsp_t rsp;
    logic [5:0] water;
    logic role;
    logic [2:0] align;
    logic [2:0] txlast;
    logic ovfl;
    logic [2:0] last_bits;
    rff_phase_t phase;
    logic [2:0] phase_code;
    logic id_busy;
    logic [3:0] id_cnt;
    logic rx_busy;
    logic [2:0] rx_pos;
    logic [7:0] rx_acc;
    logic rx_pend;
    logic [7:0] rx_hold;
    logic tx_pend;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic tx_start;
    logic halt;
    logic go;
    logic hi;
    logic lo;
  } rff_top_st_t;

endpackage

// >>> src/rff_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "rff_defs.svh"

module rff_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `RFF_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic sys_clk_i, // System clock
  input wire logic rst_i, // Async reset, active high
  input wire logic push_i, // Store wdata_i unless full
  input wire logic [WIDTH-1:0] wdata_i, // Byte to store
  input wire logic pop_i, // Drop head unless empty
  input wire logic flush_i, // Clear pointers, wins over push
  output logic [WIDTH-1:0] rdata_o, // Head entry
  output logic [AW:0] count_o, // Entries held
  output logic full_o, // No room left
  output logic empty_o // Nothing held
);
  import rff_pkg::*;

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } rff_fifo_st_t;

  rff_fifo_st_t s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_push, do_pop;

  assign full_o = s_q.cnt == (AW+1)'(DEPTH);
  assign empty_o = s_q.cnt == '0;
  assign count_o = s_q.cnt;
  assign rdata_o = mem[s_q.rp];
  assign do_push = push_i & ~full_o & ~flush_i;
  assign do_pop = pop_i & ~empty_o & ~flush_i;

  always_comb begin
    s_d = s_q;
    if (flush_i) begin
      s_d = '0;
    end else begin
      if (do_push) s_d.wp = s_q.wp + 1'b1;
      if (do_pop) s_d.rp = s_q.rp + 1'b1;
      s_d.cnt = s_q.cnt + {{AW{1'b0}}, do_push}
                - {{AW{1'b0}}, do_pop};
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Storage has no reset; only the pointers say what is valid
  always_ff @(posedge sys_clk_i) begin
    if (do_push) mem[s_q.wp] <= wdata_i;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  chk_count_up: assert property (
    do_push && !do_pop |=> count_o == $past(count_o) + 1'b1)
    else $error("fill count did not rise on push");
  chk_count_down: assert property (
    do_pop && !do_push |=> count_o == $past(count_o) - 1'b1)
    else $error("fill count did not fall on pop");
  chk_flush_empty: assert property (
    flush_i |=> empty_o)
    else $error("flush left data in buffer");

endmodule // rff_fifo
`default_nettype wire

// >>> src/rff_top.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rff_defs.svh"

module rff_top #(
  parameter int DEPTH = `RFF_DEPTH,
  parameter int LW = $clog2(DEPTH) + 1,
  parameter logic [79:0] STORED_ID = 80'h0123_4567_89AB_CDEF_0F1E // Arbitrary
) (
  input wire logic sys_clk_i, // 200 MHz system clock
  input wire logic rst_i, // Async reset, active high
  input wire rff_pkg::rff_apb_req_t apb_req_i, // APB request
  output rff_pkg::rff_apb_rsp_t apb_rsp_o, // APB response
  input wire logic transceive_active_i, // Exchange command running
  input wire logic tx_pop_i, // Modem asks for next byte
  input wire logic tx_done_i, // Modem finished sending
  input wire logic rx_bit_valid_i, // Received bit strobe
  input wire logic rx_bit_i, // Received bit value
  input wire logic rx_frame_end_i, // Received frame ended
  output logic [7:0] tx_byte_o, // Byte handed to modem
  output logic tx_byte_valid_o, // Pulse: tx_byte_o is valid
  output logic tx_start_o, // Pulse: begin transmission
  output logic [2:0] tx_final_bit_count_o, // Bits sent of last byte
  output logic [2:0] rx_first_bit_position_o, // Rx alignment
  output logic [2:0] modem_phase_o, // Modem phase code
  output logic timer_halt_o, // Pulse: stop timer
  output logic timer_go_o, // Pulse: start timer
  output logic initiator_o, // Role: 1 initiator, 0 target
  output logic near_full_alert_o, // Little free space
  output logic near_empty_alert_o, // Few bytes held
  output logic overflow_error_flag_o // Push to full buffer or received byte lost
);
  import rff_pkg::*;

  rff_top_st_t s_q, s_d;
  logic xfer, wr, rde, mapped, ctl_wr;
  logic push, pop, flush, served, data_rd_open;
  logic [7:0] push_byte, rd, fifo_rdata, racc;
  logic [2:0] rpos;
  logic rbyte;
  logic [LW-1:0] level;
  logic fifo_full, fifo_empty;

  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] idx);
    return addr[7:2] == idx[5:0];
  endfunction

  function automatic logic [2:0] phase_code(input rff_phase_t p);
    unique case (p)
      RFF_IDLE: return `RFF_PHASE_IDLE;
      RFF_WAIT: return `RFF_PHASE_WAIT;
      RFF_SEND: return `RFF_PHASE_SEND;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Buffer
  // ----------------------------------------------------------------
  rff_fifo #(
    .WIDTH(8),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .push_i(push),
    .wdata_i(push_byte),
    .pop_i(pop),
    .flush_i(flush),
    .rdata_o(fifo_rdata),
    .count_o(level),
    .full_o(fifo_full),
    .empty_o(fifo_empty)
  );

  assign xfer = apb_req_i.psel & apb_req_i.penable & s_q.rsp.pready;
  assign wr = xfer & apb_req_i.pwrite;
  assign rde = xfer & ~apb_req_i.pwrite;
  assign ctl_wr = wr & hit(apb_req_i.paddr, `RFF_IDX_CTRL);
  assign data_rd_open = apb_req_i.psel & ~apb_req_i.pwrite &
                        hit(apb_req_i.paddr, `RFF_IDX_DATA);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    push = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    served = 1'b0;
    push_byte = '0;
    rd = '0;
    mapped = 1'b1;

    // Read-back; write-only strobes always read as zero
    if (hit(apb_req_i.paddr, `RFF_IDX_DATA)) begin
      rd = fifo_empty ? 8'h00 : fifo_rdata;
    end else if (hit(apb_req_i.paddr, `RFF_IDX_LEVEL)) begin
      rd = 8'(level);
    end else if (hit(apb_req_i.paddr, `RFF_IDX_WATER)) begin
      rd = {2'b00, s_q.water};
    end else if (hit(apb_req_i.paddr, `RFF_IDX_CTRL)) begin
      rd[`RFF_BIT_IDCOPY] = s_q.id_busy;
      rd[`RFF_BIT_ROLE] = s_q.role;
      rd[`RFF_LOW3_LSB +: 3] = s_q.last_bits;
    end else if (hit(apb_req_i.paddr, `RFF_IDX_FRAME)) begin
      rd[`RFF_ALIGN_LSB +: 3] = s_q.align;
      rd[`RFF_LOW3_LSB +: 3] = s_q.txlast;
    end else if (hit(apb_req_i.paddr, `RFF_IDX_ERR)) begin
      rd[`RFF_BIT_OVFL] = s_q.ovfl;
    end else if (hit(apb_req_i.paddr, `RFF_IDX_STAT)) begin
      rd[`RFF_BIT_HI] = s_q.hi;
      rd[`RFF_BIT_LO] = s_q.lo;
      rd[`RFF_PHASE_LSB +: 3] = s_q.phase_code;
    end else begin
      mapped = 1'b0;
    end

    // One wait state: the answer comes from flops
    s_d.rsp.pready = apb_req_i.psel & apb_req_i.penable
                     & ~s_q.rsp.pready;
    s_d.rsp.pslverr = s_d.rsp.pready & ~mapped;
    s_d.rsp.prdata = {24'h000000, rd};

    // Register writes
    if (wr && hit(apb_req_i.paddr, `RFF_IDX_WATER)) begin
      s_d.water = apb_req_i.pwdata[5:0];
    end
    if (wr && hit(apb_req_i.paddr, `RFF_IDX_LEVEL) &&
        apb_req_i.pwdata[`RFF_BIT_FLUSH]) begin
      flush = 1'b1;
      s_d.ovfl = 1'b0;
    end
    s_d.halt = ctl_wr & apb_req_i.pwdata[`RFF_BIT_HALT];
    s_d.go = ctl_wr & apb_req_i.pwdata[`RFF_BIT_GO];
    if (ctl_wr) begin
      s_d.role = apb_req_i.pwdata[`RFF_BIT_ROLE];
      if (apb_req_i.pwdata[`RFF_BIT_IDCOPY] && !s_q.id_busy) begin
        s_d.id_busy = 1'b1;
        s_d.id_cnt = '0;
      end
    end
    if (wr && hit(apb_req_i.paddr, `RFF_IDX_FRAME)) begin
      s_d.align = apb_req_i.pwdata[`RFF_ALIGN_LSB +: 3];
      s_d.txlast = apb_req_i.pwdata[`RFF_LOW3_LSB +: 3];
    end

    // Modem phase; launch counts only while waiting for it
    s_d.tx_start = 1'b0;
    unique case (s_q.phase)
      RFF_IDLE: begin
        if (transceive_active_i) s_d.phase = RFF_WAIT;
      end
      RFF_WAIT: begin
        if (wr && hit(apb_req_i.paddr, `RFF_IDX_FRAME) &&
            apb_req_i.pwdata[`RFF_BIT_LAUNCH]) begin
          s_d.phase = RFF_SEND;
          s_d.tx_start = 1'b1;
        end
      end
      RFF_SEND: begin
        if (tx_done_i) s_d.phase = RFF_WAIT;
      end
    endcase
    if (!transceive_active_i) begin
      s_d.phase = RFF_IDLE;
      s_d.tx_start = 1'b0;
    end
    s_d.phase_code = phase_code(s_d.phase);

    // Pops: host first; modem waits while any APB transfer is open
    // so the read data latched in the access phase stays the head
    if (rde && hit(apb_req_i.paddr, `RFF_IDX_DATA)) begin
      pop = ~fifo_empty;
    end else if (s_q.tx_pend && !fifo_empty && !apb_req_i.psel) begin
      pop = 1'b1;
      served = 1'b1;
    end
    s_d.tx_valid = served;
    if (served) s_d.tx_byte = fifo_rdata;
    s_d.tx_pend = (s_q.tx_pend & ~served) | tx_pop_i;

    // Pushes: host, then received byte, then identifier copy
    if (wr && hit(apb_req_i.paddr, `RFF_IDX_DATA)) begin
      push = 1'b1;
      push_byte = apb_req_i.pwdata[7:0];
    end else if (flush || data_rd_open) begin
      // Internal pushes wait while a data port read is open, so an
      // empty read cannot pop a byte that arrived after prdata latched
      push = 1'b0;
    end else if (s_q.rx_pend) begin
      push = 1'b1;
      push_byte = s_q.rx_hold;
      s_d.rx_pend = 1'b0;
    end else if (s_q.id_busy) begin
      push = 1'b1;
      push_byte = STORED_ID[{s_q.id_cnt, 3'b000} +: 8];
      s_d.id_cnt = s_q.id_cnt + 1'b1;
      if (s_q.id_cnt == `RFF_ID_LAST) s_d.id_busy = 1'b0;
    end
    // Set wins over the flush clear above
    if (push && fifo_full) s_d.ovfl = 1'b1;

    // Receive bit assembly from the alignment position
    rpos = s_q.rx_busy ? s_q.rx_pos : s_q.align;
    racc = s_q.rx_busy ? s_q.rx_acc : 8'h00;
    rbyte = 1'b0;
    if (rx_bit_valid_i) begin
      racc[rpos] = rx_bit_i;
      s_d.rx_busy = 1'b1;
      if (rpos == `RFF_MSB_POS) rbyte = 1'b1;
      rpos = rpos + 1'b1;
    end
    if (rx_frame_end_i && (s_q.rx_busy || rx_bit_valid_i)) begin
      s_d.rx_busy = 1'b0;
      s_d.last_bits = rpos;
      if (rpos != '0) rbyte = 1'b1;
    end
    s_d.rx_pos = rpos;
    s_d.rx_acc = rbyte ? 8'h00 : racc;
    if (rbyte) begin
      // A byte still waiting is overwritten; flag the loss
      if (s_d.rx_pend) s_d.ovfl = 1'b1;
      s_d.rx_hold = racc;
      s_d.rx_pend = 1'b1;
    end

    // Alerts follow the fill count one cycle late
    s_d.hi = (LW'(DEPTH) - level) <= LW'(s_q.water);
    s_d.lo = level <= LW'(s_q.water);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.water <= `RFF_WATER_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign apb_rsp_o = s_q.rsp;
  assign tx_byte_o = s_q.tx_byte;
  assign tx_byte_valid_o = s_q.tx_valid;
  assign tx_start_o = s_q.tx_start;
  assign tx_final_bit_count_o = s_q.txlast;
  assign rx_first_bit_position_o = s_q.align;
  assign modem_phase_o = s_q.phase_code;
  assign timer_halt_o = s_q.halt;
  assign timer_go_o = s_q.go;
  assign initiator_o = s_q.role;
  assign near_full_alert_o = s_q.hi;
  assign near_empty_alert_o = s_q.lo;
  assign overflow_error_flag_o = s_q.ovfl;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  chk_ovfl_set: assert property (
    wr && hit(apb_req_i.paddr, `RFF_IDX_DATA) && fifo_full
    |=> overflow_error_flag_o && level == LW'(DEPTH))
    else $error("overflow not flagged on full write");
  chk_hi_alert: assert property (
    !$past(rst_i) |-> near_full_alert_o ==
      ((LW'(DEPTH) - $past(level)) <= LW'($past(s_q.water))))
    else $error("near-full alert wrong");
  chk_lo_alert: assert property (
    !$past(rst_i) |-> near_empty_alert_o ==
      ($past(level) <= LW'($past(s_q.water))))
    else $error("near-empty alert wrong");
  chk_halt_pulse: assert property (
    timer_halt_o |-> $past(ctl_wr && apb_req_i.pwdata[`RFF_BIT_HALT])
      ##1 !timer_halt_o)
    else $error("halt strobe without cause");
  chk_go_pulse: assert property (
    ctl_wr && apb_req_i.pwdata[`RFF_BIT_GO] |=> timer_go_o ##1 !timer_go_o)
    else $error("go strobe not one cycle");
  chk_idcopy_len: assert property (
    $rose(s_q.id_busy) |-> s_q.id_busy [*8])
    else $error("identifier copy ended too early");
  chk_role_bit: assert property (
    ctl_wr |=> initiator_o == $past(apb_req_i.pwdata[`RFF_BIT_ROLE]))
    else $error("role bit not stored");
  chk_launch_gate: assert property (
    tx_start_o |-> $past(transceive_active_i) &&
      $past(modem_phase_o) == `RFF_PHASE_WAIT)
    else $error("launch outside exchange command");
  chk_rx_align: assert property (
    rx_bit_valid_i && !s_q.rx_busy && !rx_frame_end_i &&
    s_q.align != `RFF_MSB_POS
    |=> s_q.rx_acc[$past(s_q.align)] == $past(rx_bit_i))
    else $error("first bit not at alignment");
  chk_flush_reads: assert property (
    apb_rsp_o.pready && !apb_req_i.pwrite &&
    hit(apb_req_i.paddr, `RFF_IDX_LEVEL)
    |-> !apb_rsp_o.prdata[`RFF_BIT_FLUSH])
    else $error("flush bit read back as one");

  cov_id_copy: cover property ($fell(s_q.id_busy));
  cov_launch: cover property (tx_start_o);
  cov_ovfl: cover property ($rose(overflow_error_flag_o));
  cov_rx_part: cover property (rx_frame_end_i && s_q.rx_pos != '0);

endmodule // rff_top
`default_nettype wire

// >>> testbench/rff_modem_model.sv
`timescale 1ns/1ps
`default_nettype none

module rff_modem_model (
  input wire logic sys_clk_i, // System clock
  input wire logic [7:0] tx_byte_i, // Byte handed over
  input wire logic tx_byte_valid_i, // Handed byte is new
  input wire logic tx_start_i, // Launch pulse
  output logic tx_pop_o, // Ask for next byte
  output logic tx_done_o, // Sending finished
  output logic rx_bit_valid_o, // Bit strobe
  output logic rx_bit_o, // Bit value
  output logic rx_frame_end_o // Frame ended
);
  int n_start = 0;
  logic [7:0] got_byte;
  logic got_ok;

  initial begin
    tx_pop_o = 1'b0;
    tx_done_o = 1'b0;
    rx_bit_valid_o = 1'b0;
    rx_bit_o = 1'b0;
    rx_frame_end_o = 1'b0;
  end

  always @(posedge sys_clk_i) begin
    if (tx_start_i === 1'b1) n_start++;
  end

  // ----------------------------------------------------------------
  // Bits go out one per cycle; the idle line shows the inverse level
  // ----------------------------------------------------------------
  task automatic send_bits(input logic [15:0] bits, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge sys_clk_i);
      rx_bit_valid_o <= 1'b1;
      rx_bit_o <= bits[k];
    end
    @(posedge sys_clk_i);
    rx_bit_valid_o <= 1'b0;
    rx_bit_o <= ~bits[n-1];
    rx_frame_end_o <= 1'b1;
    @(posedge sys_clk_i);
    rx_frame_end_o <= 1'b0;
  endtask

  task automatic pop_byte();
    got_ok = 1'b0;
    @(posedge sys_clk_i);
    tx_pop_o <= 1'b1;
    @(posedge sys_clk_i);
    tx_pop_o <= 1'b0;
    for (int k = 0; k < 20 && !got_ok; k++) begin
      @(posedge sys_clk_i);
      if (tx_byte_valid_i === 1'b1) begin
        got_ok = 1'b1;
        got_byte = tx_byte_i;
      end
    end
  endtask

  task automatic done_pulse();
    @(posedge sys_clk_i);
    tx_done_o <= 1'b1;
    @(posedge sys_clk_i);
    tx_done_o <= 1'b0;
  endtask
endmodule // rff_modem_model

`default_nettype wire

// >>> testbench/rff_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rff_defs.svh"

module rff_top_tb;
  import rff_pkg::*;
  localparam logic [79:0] ID = 80'h1122_3344_5566_7788_99AA; // Arbitrary
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic act = 1'b0;
  rff_apb_req_t req = '0;
  rff_apb_rsp_t rsp;
  logic pop, done, bv, bit_v, fend, tvalid, tstart, halt, go, init;
  logic nfull, nempty, ovfl;
  logic [7:0] tbyte;
  logic [2:0] txl, ralign, phase;
  int n_errors = 0;
  int num_checks = 0;
  int n_halt = 0;
  int n_go = 0;
  logic [7:0] rv;
  logic err;

  always #2.5 clk = ~clk;

  rff_top #(.STORED_ID(ID)) u_dut (
    .sys_clk_i(clk), .rst_i(rst), .apb_req_i(req), .apb_rsp_o(rsp),
    .transceive_active_i(act), .tx_pop_i(pop), .tx_done_i(done),
    .rx_bit_valid_i(bv), .rx_bit_i(bit_v), .rx_frame_end_i(fend),
    .tx_byte_o(tbyte), .tx_byte_valid_o(tvalid), .tx_start_o(tstart),
    .tx_final_bit_count_o(txl), .rx_first_bit_position_o(ralign),
    .modem_phase_o(phase), .timer_halt_o(halt), .timer_go_o(go),
    .initiator_o(init), .near_full_alert_o(nfull),
    .near_empty_alert_o(nempty), .overflow_error_flag_o(ovfl)
  );

  rff_modem_model u_modem (
    .sys_clk_i(clk), .tx_byte_i(tbyte), .tx_byte_valid_i(tvalid),
    .tx_start_i(tstart), .tx_pop_o(pop), .tx_done_o(done),
    .rx_bit_valid_o(bv), .rx_bit_o(bit_v), .rx_frame_end_o(fend)
  );

  always @(posedge clk) begin
    if (halt === 1'b1) n_halt++;
    if (go === 1'b1) n_go++;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_v(input string what, input logic [7:0] e,
                       input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", what, e, g);
    end
  endtask

  task automatic chk_b(input string what, input logic e, input logic g);
    chk_v(what, {7'h00, e}, {7'h00, g});
  endtask

  // ----------------------------------------------------------------
  // APB master: request held until pready is seen at a rising edge
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [7:0] rd);
    int k;
    k = 0;
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= {idx[5:0], 2'b00};
    req.pwdata <= {24'h000000, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    if (k >= 20) n_errors++;
    rd = rsp.prdata[7:0];
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    apb(1'b1, idx, d, x);
  endtask

  task automatic rd(input logic [7:0] idx);
    apb(1'b0, idx, 8'h00, rv);
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
  endtask

  initial begin
    #100_000;
    n_errors++;
    results();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    settle();
    rd(`RFF_IDX_LEVEL); chk_v("level rst", 8'h00, rv);
    rd(`RFF_IDX_WATER); chk_v("water rst", 8'h08, rv);
    rd(`RFF_IDX_CTRL); chk_v("ctrl rst", 8'h00, rv);
    rd(`RFF_IDX_FRAME); chk_v("frame rst", 8'h00, rv);
    rd(8'h20); chk_b("slverr", 1'b1, err);
    $display("test reset done");

    for (int i = 0; i < 64; i++) begin
      wr(`RFF_IDX_DATA, 8'(i) ^ 8'h5A);
      settle();
      chk_b("near_full", i >= 55, nfull);
      chk_b("near_empty", i <= 7, nempty);
    end
    rd(`RFF_IDX_LEVEL); chk_v("level full", 8'h40, rv);
    wr(`RFF_IDX_DATA, 8'hEE);
    settle();
    chk_b("ovfl", 1'b1, ovfl);
    rd(`RFF_IDX_ERR); chk_b("err ovfl", 1'b1, rv[`RFF_BIT_OVFL]);
    rd(`RFF_IDX_LEVEL); chk_v("level kept", 8'h40, rv);
    for (int i = 0; i < 64; i++) begin
      rd(`RFF_IDX_DATA); chk_v("pop", 8'(i) ^ 8'h5A, rv);
    end
    rd(`RFF_IDX_LEVEL); chk_v("level empty", 8'h00, rv);
    $display("test fill done");

    wr(`RFF_IDX_DATA, 8'h11);
    wr(`RFF_IDX_DATA, 8'h22);
    wr(`RFF_IDX_LEVEL, 8'h80);
    settle();
    chk_b("ovfl flushed", 1'b0, ovfl);
    rd(`RFF_IDX_LEVEL); chk_v("level flushed", 8'h00, rv);
    $display("test flush done");

    wr(`RFF_IDX_WATER, 8'h03);
    rd(`RFF_IDX_WATER); chk_v("water", 8'h03, rv);
    for (int i = 0; i < 4; i++) begin
      wr(`RFF_IDX_DATA, 8'h30);
      settle();
      chk_b("near_empty thr", i <= 2, nempty);
    end
    wr(`RFF_IDX_LEVEL, 8'h80);
    wr(`RFF_IDX_WATER, 8'h08);
    $display("test threshold done");

    wr(`RFF_IDX_CTRL, 8'hC0);
    settle();
    chk_v("halt pulses", 8'h01, 8'(n_halt));
    chk_v("go pulses", 8'h01, 8'(n_go));
    rd(`RFF_IDX_CTRL); chk_v("ctrl strobes", 8'h00, rv);
    wr(`RFF_IDX_CTRL, 8'h10);
    settle();
    chk_b("initiator", 1'b1, init);
    rd(`RFF_IDX_CTRL); chk_v("ctrl role", 8'h10, rv);
    $display("test control done");

    wr(`RFF_IDX_CTRL, 8'h30);
    for (int k = 0; k < 20; k++) begin
      rd(`RFF_IDX_CTRL);
      if (rv[`RFF_BIT_IDCOPY] === 1'b0) break;
    end
    chk_v("ctrl after copy", 8'h10, rv);
    rd(`RFF_IDX_LEVEL); chk_v("id level", 8'h0A, rv);
    for (int i = 0; i < 10; i++) begin
      rd(`RFF_IDX_DATA); chk_v("id byte", ID[8*i +: 8], rv);
    end
    wr(`RFF_IDX_CTRL, 8'h00);
    $display("test identifier done");

    // Nonzero alignment only for this bitwise anticollision frame
    wr(`RFF_IDX_FRAME, 8'h35);
    rd(`RFF_IDX_FRAME); chk_v("frame", 8'h35, rv);
    chk_v("align out", 8'h03, {5'h00, ralign});
    chk_v("txlast out", 8'h05, {5'h00, txl});
    u_modem.send_bits(16'h005B, 7);
    settle();
    rd(`RFF_IDX_LEVEL); chk_v("rx level", 8'h02, rv);
    rd(`RFF_IDX_DATA); chk_v("rx byte0", 8'hD8, rv);
    rd(`RFF_IDX_DATA); chk_v("rx byte1", 8'h02, rv);
    rd(`RFF_IDX_CTRL); chk_v("rx last bits", 8'h02, rv);
    wr(`RFF_IDX_FRAME, 8'h00);
    $display("test receive done");

    wr(`RFF_IDX_FRAME, 8'h80);
    settle();
    chk_v("no launch", 8'h00, 8'(u_modem.n_start));
    act <= 1'b1;
    settle();
    chk_v("phase wait", 8'h01, {5'h00, phase});
    rd(`RFF_IDX_STAT); chk_v("status wait", 8'h11, rv);
    wr(`RFF_IDX_DATA, 8'hA5);
    wr(`RFF_IDX_FRAME, 8'h80);
    settle();
    chk_v("launch", 8'h01, 8'(u_modem.n_start));
    chk_v("phase send", 8'h03, {5'h00, phase});
    rd(`RFF_IDX_FRAME); chk_v("launch reads", 8'h00, rv);
    u_modem.pop_byte();
    chk_b("tx served", 1'b1, u_modem.got_ok);
    chk_v("tx byte", 8'hA5, u_modem.got_byte);
    u_modem.done_pulse();
    settle();
    chk_v("phase back", 8'h01, {5'h00, phase});
    act <= 1'b0;
    settle();
    chk_v("phase idle", 8'h00, {5'h00, phase});
    $display("test launch done");
    results();
  end
endmodule // rff_top_tb

`default_nettype wire
